// File: rtl/alert_summary_status_regs.sv
/*
 * Alert summary and cell overvoltage status registers behind an AHB-Lite slave.
 * Assumes acquisition and calibration engines on ref_clk that present one-cycle result strobes,
 * and a single AHB-Lite master whose hready is this slave's hreadyout.
 */
`timescale 1ns/100ps
`include "alert_cfg.svh"

// How it works
// - Bit 15 ORs ADC cell overvoltage alerts
// - Bit 14 ORs comparator cell overvoltage alerts
// - Bit 13 ORs ADC cell undervoltage alerts
// - Bit 12 ORs comparator cell undervoltage alerts
// - Bit 11 ORs ADC auxiliary cold alerts
// - Bit 10 ORs comparator auxiliary cold alerts
// - Bit 9 ORs ADC auxiliary hot alerts
// - Bit 8 ORs comparator auxiliary hot alerts
// - Summary bits clear only when all resolved
// - Bit 4 flags bad ADC offset calibration
// - Fault clears on later in-bounds calibration or write
// - Bit 3 flags bad ramp offset calibration
// - Bit 2 flags bad ratiometric offset calibration
// - Bit 1 flags bad pyramid gain calibration
// - Bit 0 flags bad ramp gain calibration
// - Cell overvoltage bits, cell n at n-1, enabled only
// - Polarity selects unipolar or bipolar threshold
// - Cell overvoltage bit clears when condition gone
// - Summary register ignores writes
module alert_summary_status_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire alert_pkg::ahb_req_s ahb_req,
  output alert_pkg::ahb_rsp_s ahb_rsp,
  input wire alert_pkg::acq_in_s acq_in,
  input wire alert_pkg::cal_in_s cal_in
);

  // ****************************************************************************
  // Helper functions
  // ****************************************************************************

  // Overvoltage test of one cell against the threshold its polarity selects.
  function automatic logic cell_over(
    input logic [`DATA_W-1:0] volt,
    input logic bipolar,
    input logic [`DATA_W-1:0] uni_thr,
    input logic [`DATA_W-1:0] bip_thr
  );
    logic hit;
    hit = 1'b0;
    if (bipolar) begin
      hit = $signed(volt) > $signed(bip_thr);
    end else begin
      hit = volt > uni_thr;
    end
    return hit;
  endfunction

  // Bounds check of a calibration value: offsets are signed and near zero, gains sit in a band.
  function automatic logic cal_in_bounds(
    input int unsigned kind,
    input logic [`DATA_W-1:0] value
  );
    logic ok;
    ok = 1'b0;
    if (kind == `SUM_CAL_PYRAMID_GAIN || kind == `SUM_CAL_RAMP_GAIN) begin
      ok = (value >= `CAL_GAIN_MIN) && (value <= `CAL_GAIN_MAX);
    end else begin
      ok = ($signed(value) <= $signed(`CAL_OFFSET_LIMIT)) && ($signed(value) >= -$signed(`CAL_OFFSET_LIMIT));
    end
    return ok;
  endfunction

  // Address decode of the readable map; unmapped addresses read as zero.
  function automatic logic [31:0] read_word(
    input logic [`ADDR_DECODE_BITS-1:0] addr,
    input alert_pkg::state_s s
  );
    logic [31:0] data;
    data = 32'h0000_0000;
    if (addr == `ADDR_ALERT_SUMMARY) begin
      data = {16'h0000, s.alert_summary};
    end else if (addr == `ADDR_CELL_OV_ALERTS) begin
      data = {18'h00000, s.cell_ov_flags};
    end else if (addr == `ADDR_UNIPOLAR_OV_THRESHOLD) begin
      data = {16'h0000, s.unipolar_ov_threshold};
    end else if (addr == `ADDR_BIPOLAR_OV_THRESHOLD) begin
      data = {16'h0000, s.bipolar_ov_threshold};
    end else if (addr == `ADDR_CELL_POLARITY) begin
      data = {18'h00000, s.cell_polarity};
    end else if (addr == `ADDR_CELL_OV_ALERT_ENABLE) begin
      data = {18'h00000, s.cell_ov_alert_enable};
    end else begin
      for (int k = 0; k < `NUM_CAL; k++) begin
        if (addr == `ADDR_CAL_VALUE_BASE + `ADDR_DECODE_BITS'(4 * k)) begin
          data = {16'h0000, s.cal_value[k]};
        end
      end
    end
    return data;
  endfunction

  // ****************************************************************************
  // State and per-cell comparison
  // ****************************************************************************

  alert_pkg::state_s st;
  alert_pkg::state_s next_st;
  logic [`NUM_CELLS-1:0] cell_ov_now;
  logic accept;
  logic [`ADDR_DECODE_BITS-1:0] req_addr;

  assign req_addr = ahb_req.haddr[`ADDR_DECODE_BITS-1:0];
  assign accept = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CELLS; gi++) begin : g_cell
      // Disabled cells never raise an alert.
      assign cell_ov_now[gi] = st.cell_ov_alert_enable[gi] &&
        cell_over(acq_in.cell_volt[gi], st.cell_polarity[gi],
                  st.unipolar_ov_threshold, st.bipolar_ov_threshold);
    end
  endgenerate

  // ****************************************************************************
  // Next state
  // ****************************************************************************

  always_comb begin
    logic [`NUM_CAL-1:0] cal_set;
    logic [`NUM_CAL-1:0] cal_clr;
    logic [`NUM_CELLS-1:0] ov_new;
    logic wr_word;
    cal_set = '0;
    cal_clr = '0;
    ov_new = '0;
    wr_word = 1'b0;
    next_st = st;

    // Bus: writes complete with no wait state, reads take one wait state so that
    // a read right behind a write returns the freshly written value.
    case (st.phase)
      alert_pkg::PH_IDLE: begin
        next_st.hreadyout = 1'b1;
      end
      alert_pkg::PH_WRITE: begin
        next_st.hreadyout = 1'b1;
        next_st.phase = alert_pkg::PH_IDLE;
        wr_word = 1'b1;
      end
      alert_pkg::PH_READ: begin
        next_st.hrdata = read_word(st.wr_addr, st);
        next_st.hreadyout = 1'b1;
        next_st.phase = alert_pkg::PH_IDLE;
      end
      default: begin
        next_st.phase = alert_pkg::PH_IDLE;
        next_st.hreadyout = 1'b1;
      end
    endcase

    if (accept && st.hreadyout) begin
      next_st.wr_addr = req_addr;
      if (ahb_req.hwrite && ahb_req.hsize == `HSIZE_WORD) begin
        next_st.phase = alert_pkg::PH_WRITE;
      end else if (!ahb_req.hwrite) begin
        next_st.phase = alert_pkg::PH_READ;
        next_st.hreadyout = 1'b0;
      end else begin
        next_st.phase = alert_pkg::PH_IDLE;
      end
    end

    // Writes to the status registers and unmapped addresses fall through untouched.
    if (wr_word) begin
      if (st.wr_addr == `ADDR_ALERT_SUMMARY) begin
        next_st.alert_summary = st.alert_summary;
      end else if (st.wr_addr == `ADDR_UNIPOLAR_OV_THRESHOLD) begin
        next_st.unipolar_ov_threshold = ahb_req.hwdata[`DATA_W-1:0];
      end else if (st.wr_addr == `ADDR_BIPOLAR_OV_THRESHOLD) begin
        next_st.bipolar_ov_threshold = ahb_req.hwdata[`DATA_W-1:0];
      end else if (st.wr_addr == `ADDR_CELL_POLARITY) begin
        next_st.cell_polarity = ahb_req.hwdata[`NUM_CELLS-1:0];
      end else if (st.wr_addr == `ADDR_CELL_OV_ALERT_ENABLE) begin
        next_st.cell_ov_alert_enable = ahb_req.hwdata[`NUM_CELLS-1:0];
      end else begin
        for (int k = 0; k < `NUM_CAL; k++) begin
          if (st.wr_addr == `ADDR_CAL_VALUE_BASE + `ADDR_DECODE_BITS'(4 * k)) begin
            next_st.cal_value[k] = ahb_req.hwdata[`DATA_W-1:0];
            if (cal_in_bounds(k, ahb_req.hwdata[`DATA_W-1:0])) begin
              cal_clr[k] = 1'b1;
            end else begin
              cal_set[k] = 1'b1;
            end
          end
        end
      end
    end

    // A calibration run loads its result; an out-of-bounds result raises the fault.
    for (int k = 0; k < `NUM_CAL; k++) begin
      if (cal_in.done[k]) begin
        next_st.cal_value[k] = cal_in.value[k];
        if (cal_in_bounds(k, cal_in.value[k])) begin
          cal_clr[k] = 1'b1;
        end else begin
          cal_set[k] = 1'b1;
        end
      end
    end

    // A fault raised in the same cycle as an in-bounds result stays raised.
    for (int k = 0; k < `NUM_CAL; k++) begin
      if (cal_set[k]) begin
        next_st.alert_summary[k] = 1'b1;
      end else if (cal_clr[k]) begin
        next_st.alert_summary[k] = 1'b0;
      end
    end

    // Each acquisition re-evaluates every alert, so a summary bit drops only when
    // nothing it covers is still active.
    if (acq_in.valid) begin
      ov_new = cell_ov_now;
      next_st.cell_ov_flags = ov_new;
      next_st.alert_summary[`SUM_CELL_OV_ADC] = |ov_new;
      next_st.alert_summary[`SUM_CELL_OV_CMP] = |acq_in.cell_ov_cmp_flags;
      next_st.alert_summary[`SUM_CELL_UV_ADC] = |acq_in.cell_uv_flags;
      next_st.alert_summary[`SUM_CELL_UV_CMP] = |acq_in.cell_uv_cmp_flags;
      next_st.alert_summary[`SUM_AUX_OV_ADC] = |acq_in.aux_ov_flags;
      next_st.alert_summary[`SUM_AUX_OV_CMP] = |acq_in.aux_ov_cmp_flags;
      next_st.alert_summary[`SUM_AUX_UV_ADC] = |acq_in.aux_uv_flags;
      next_st.alert_summary[`SUM_AUX_UV_CMP] = |acq_in.aux_uv_cmp_flags;
    end

    next_st.alert_summary[7:5] = 3'h0;
  end

  // ****************************************************************************
  // State register
  // ****************************************************************************

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.phase <= alert_pkg::PH_IDLE;
      st.hreadyout <= 1'b1;
      st.unipolar_ov_threshold <= `RESET_UNIPOLAR_OV_THRESHOLD;
      st.bipolar_ov_threshold <= `RESET_BIPOLAR_OV_THRESHOLD;
      st.cell_polarity <= `RESET_CELL_POLARITY;
      st.cell_ov_alert_enable <= `RESET_CELL_OV_ALERT_ENABLE;
      st.cal_value <= {`NUM_CAL{`RESET_CAL_VALUE}};
      st.cell_ov_flags <= `RESET_CELL_OV_ALERTS;
      st.alert_summary <= `RESET_ALERT_SUMMARY;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************************************************
  // Bus response
  // ****************************************************************************

  always_comb begin
    ahb_rsp.hreadyout = st.hreadyout;
    ahb_rsp.hresp = `HRESP_OKAY;
    ahb_rsp.hrdata = st.hrdata;
  end

endmodule

// File: rtl/alert_cfg.svh
/*
 * Address map, field positions, reset values and calibration bounds of the alert status block.
 * Assumes inclusion by the package and the block, each of which sees it only once.
 */
`ifndef ALERT_CFG_SVH
`define ALERT_CFG_SVH

// ****************************************************************************
// Register indices and byte addresses
// ****************************************************************************
`define IDX_ALERT_SUMMARY 8'h07
`define IDX_CELL_OV_ALERTS 8'h08
`define ADDR_ALERT_SUMMARY 12'h01c
`define ADDR_CELL_OV_ALERTS 12'h020
`define ADDR_UNIPOLAR_OV_THRESHOLD 12'h040
`define ADDR_BIPOLAR_OV_THRESHOLD 12'h044
`define ADDR_CELL_POLARITY 12'h048
`define ADDR_CELL_OV_ALERT_ENABLE 12'h04c
`define ADDR_CAL_VALUE_BASE 12'h050
`define ADDR_DECODE_BITS 12

// ****************************************************************************
// Summary register field positions
// ****************************************************************************
`define SUM_CELL_OV_ADC 15
`define SUM_CELL_OV_CMP 14
`define SUM_CELL_UV_ADC 13
`define SUM_CELL_UV_CMP 12
`define SUM_AUX_OV_ADC 11
`define SUM_AUX_OV_CMP 10
`define SUM_AUX_UV_ADC 9
`define SUM_AUX_UV_CMP 8
`define SUM_CAL_ADC_OFFSET 4
`define SUM_CAL_RAMP_OFFSET 3
`define SUM_CAL_RATIO_OFFSET 2
`define SUM_CAL_PYRAMID_GAIN 1
`define SUM_CAL_RAMP_GAIN 0

// ****************************************************************************
// Sizes, reset values and calibration bounds
// ****************************************************************************
`define NUM_CELLS 14
`define NUM_AUX 6
`define NUM_CAL 5
`define DATA_W 16
`define RESET_ALERT_SUMMARY 16'h0000
`define RESET_CELL_OV_ALERTS 14'h0000
`define RESET_UNIPOLAR_OV_THRESHOLD 16'hffff
`define RESET_BIPOLAR_OV_THRESHOLD 16'h7fff
`define RESET_CELL_POLARITY 14'h0000
`define RESET_CELL_OV_ALERT_ENABLE 14'h0000
`define RESET_CAL_VALUE 16'h0000
`define CAL_OFFSET_LIMIT 16'h0100
`define CAL_GAIN_MIN 16'h7000
`define CAL_GAIN_MAX 16'h9000
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0

`endif

// File: rtl/alert_pkg.sv
/*
 * Types shared by the alert status block and its surroundings.
 * Assumes alert_cfg.svh supplies sizes; nothing here holds logic.
 */
`include "alert_cfg.svh"

package alert_pkg;

  typedef logic [`DATA_W-1:0] word16_t;

  // Bus phase of the slave, one-hot.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ = 3'b100
  } bus_phase_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_s;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_s;

  // One acquisition result: a one-cycle valid with cell readings and the alert vectors of the other paths.
  typedef struct packed {
    logic valid;
    logic [`NUM_CELLS-1:0][`DATA_W-1:0] cell_volt;
    logic [`NUM_CELLS-1:0] cell_ov_cmp_flags;
    logic [`NUM_CELLS-1:0] cell_uv_flags;
    logic [`NUM_CELLS-1:0] cell_uv_cmp_flags;
    logic [`NUM_AUX-1:0] aux_ov_flags;
    logic [`NUM_AUX-1:0] aux_ov_cmp_flags;
    logic [`NUM_AUX-1:0] aux_uv_flags;
    logic [`NUM_AUX-1:0] aux_uv_cmp_flags;
  } acq_in_s;

  // Calibration results: done[k] pulses for one cycle with value[k].
  typedef struct packed {
    logic [`NUM_CAL-1:0] done;
    logic [`NUM_CAL-1:0][`DATA_W-1:0] value;
  } cal_in_s;

  typedef struct packed {
    bus_phase_e phase;
    logic [`ADDR_DECODE_BITS-1:0] wr_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [`DATA_W-1:0] unipolar_ov_threshold;
    logic [`DATA_W-1:0] bipolar_ov_threshold;
    logic [`NUM_CELLS-1:0] cell_polarity;
    logic [`NUM_CELLS-1:0] cell_ov_alert_enable;
    logic [`NUM_CAL-1:0][`DATA_W-1:0] cal_value;
    logic [`NUM_CELLS-1:0] cell_ov_flags;
    logic [`DATA_W-1:0] alert_summary;
  } state_s;

endpackage

// File: tb/alert_status_monitor.sv
/* Port checker for the alert status block.
   Assumes a bind into alert_summary_status_regs. */
`timescale 1ns/100ps
`include "alert_cfg.svh"
module alert_status_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire alert_pkg::ahb_req_s ahb_req,
  input wire alert_pkg::ahb_rsp_s ahb_rsp,
  input wire alert_pkg::acq_in_s acq_in,
  input wire alert_pkg::cal_in_s cal_in
);
  // ********************
  // Bus and alert checks
  // ********************
  logic take;
  logic [6:0] grp;
  assign take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ce;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Groups raised by the last taken acquisition, every path but the ADC cell overvoltage one.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      grp <= 7'h00;
    end else if (acq_in.valid && ce) begin
      grp <= {|acq_in.cell_ov_cmp_flags, |acq_in.cell_uv_flags, |acq_in.cell_uv_cmp_flags, |acq_in.aux_ov_flags,
        |acq_in.aux_ov_cmp_flags, |acq_in.aux_uv_flags, |acq_in.aux_uv_cmp_flags};
    end
  end
  sequence rd_at(logic [11:0] a);
    take && !ahb_req.hwrite && ahb_req.haddr[11:0] == a ##1 ce;
  endsequence
  a_resp_okay: assert property (ahb_rsp.hresp == 1'b0)
    else $error("response not okay");
  a_read_waits: assert property (take && !ahb_req.hwrite |=> !ahb_rsp.hreadyout)
    else $error("read without wait");
  a_read_one_wait: assert property (take && !ahb_req.hwrite ##1 ce |=> ahb_rsp.hreadyout)
    else $error("read wait too long");
  a_write_no_wait: assert property (take && ahb_req.hwrite |=> ahb_rsp.hreadyout)
    else $error("write waited");
  a_rdata_holds: assert property (ahb_rsp.hreadyout && $past(ahb_rsp.hreadyout) |-> $stable(ahb_rsp.hrdata))
    else $error("read data moved");
  a_sum_spare_zero: assert property (rd_at(`ADDR_ALERT_SUMMARY) |=>
    ahb_rsp.hrdata[31:16] == 16'h0 && ahb_rsp.hrdata[7:5] == 3'h0) else $error("summary spare bits set");
  a_cell_spare_zero: assert property (rd_at(`ADDR_CELL_OV_ALERTS) |=>
    ahb_rsp.hrdata[31:14] == 18'h0) else $error("cell spare bits set");
  a_sum_cell_or: assert property (rd_at(`ADDR_ALERT_SUMMARY) |=>
    ahb_rsp.hrdata[14:12] == $past(grp[6:4])) else $error("cell summary wrong");
  a_sum_aux_or: assert property (rd_at(`ADDR_ALERT_SUMMARY) |=>
    ahb_rsp.hrdata[11:8] == $past(grp[3:0])) else $error("aux summary wrong");
  cover property (rd_at(`ADDR_CELL_OV_ALERTS));
  cover property (acq_in.valid && ce);
  cover property (|cal_in.done && ce);
endmodule
bind alert_summary_status_regs alert_status_monitor u_monitor (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
  .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .acq_in(acq_in), .cal_in(cal_in));

// File: tb/tb_top.sv
/* Self-checking bench for the alert status block: random acquisitions and calibrations.
   Assumes the package, the header and the block are compiled first. */
`timescale 1ns/100ps
`include "alert_cfg.svh"
module tb_top;
  // ********************
  // Signals and models
  // ********************
  localparam logic [11:0] sum_a = `ADDR_ALERT_SUMMARY;
  localparam logic [11:0] cov_a = `ADDR_CELL_OV_ALERTS;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] seed = 32'h8ccc;
  alert_pkg::ahb_req_s req;
  alert_pkg::ahb_rsp_s rsp;
  alert_pkg::acq_in_s acq = '0;
  alert_pkg::cal_in_s cal = '0;
  logic [15:0] uni, bip, sum_exp;
  logic [13:0] pol, en, ov_exp;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  assign req = {hsel, haddr, htrans, hwrite, hsize, hwdata, rsp.hreadyout};
  alert_summary_status_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .ahb_req(req),
    .ahb_rsp(rsp), .acq_in(acq), .cal_in(cal));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] sparse();
    return rnd() & rnd() & rnd();
  endfunction
  function automatic logic cal_ok(input int k, input logic [15:0] v);
    if (k >= 2) return $signed(v) >= -16'sh0100 && $signed(v) <= 16'sh0100;
    return v >= 16'h7000 && v <= 16'h9000;
  endfunction
  function automatic logic [13:0] ov_of(input alert_pkg::acq_in_s a);
    logic [13:0] r;
    for (int i = 0; i < 14; i++)
      r[i] = en[i] && (pol[i] ? $signed(a.cell_volt[i]) > $signed(bip) : a.cell_volt[i] > uni);
    return r;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    haddr <= {20'h0, a};
    @(posedge ref_clk);
    while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
    rd = rsp.hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 3'h2);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, rnd(), 3'h2);
    check(rd, e);
  endtask
  task automatic sum_chk();
    rd_chk(sum_a, {16'h0, sum_exp});
  endtask
  task automatic acquire(input alert_pkg::acq_in_s a);
    a.valid = 1'b1;
    acq <= a;
    @(posedge ref_clk);
    acq.valid <= 1'b0;
    @(posedge ref_clk);
    if (ce) begin
      ov_exp = ov_of(a);
      sum_exp[15:8] = {|ov_exp, |a.cell_ov_cmp_flags, |a.cell_uv_flags, |a.cell_uv_cmp_flags,
        |a.aux_ov_flags, |a.aux_ov_cmp_flags, |a.aux_uv_flags, |a.aux_uv_cmp_flags};
    end
  endtask
  task automatic calibrate(input int k, input logic [15:0] v, input logic by_bus);
    if (by_bus) begin
      wr(`ADDR_CAL_VALUE_BASE + 12'(4 * k), {16'h0, v});
    end else begin
      cal.done[k] <= 1'b1;
      cal.value[k] <= v;
      @(posedge ref_clk);
      cal.done <= 5'h00;
      @(posedge ref_clk);
    end
    sum_exp[k] = !cal_ok(k, v);
    rd_chk(`ADDR_CAL_VALUE_BASE + 12'(4 * k), {16'h0, v});
  endtask
  task automatic end_test(input string s);
    $display("test %s done: %0d checks, %0d wrong", s, check_count, fail_count);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ********************
  // Test sequence
  // ********************
  initial begin
    alert_pkg::acq_in_s a;
    logic [31:0] m;
    {uni, bip, sum_exp, pol, en, ov_exp} = {16'hffff, 16'h7fff, 16'h0, 42'h0};
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    sum_chk();
    rd_chk(cov_a, 32'h0);
    rd_chk(`ADDR_UNIPOLAR_OV_THRESHOLD, 32'hffff);
    rd_chk(`ADDR_BIPOLAR_OV_THRESHOLD, 32'h7fff);
    rd_chk(`ADDR_CELL_POLARITY, 32'h0);
    rd_chk(`ADDR_CELL_OV_ALERT_ENABLE, 32'h0);
    for (int k = 0; k < 5; k++) rd_chk(`ADDR_CAL_VALUE_BASE + 12'(4 * k), 32'h0);
    rd_chk(12'h7fc, 32'h0);
    end_test("reset");
    for (int n = 0; n < 24; n++) begin
      m = rnd();
      uni = m[15:0];
      wr(`ADDR_UNIPOLAR_OV_THRESHOLD, m);
      m = rnd();
      bip = m[15:0];
      wr(`ADDR_BIPOLAR_OV_THRESHOLD, m);
      pol = 14'(rnd());
      wr(`ADDR_CELL_POLARITY, {18'h0, pol});
      en = n == 0 ? 14'h3fff : n == 23 ? 14'h0 : 14'(sparse());
      wr(`ADDR_CELL_OV_ALERT_ENABLE, {18'h0, en});
      {a.cell_ov_cmp_flags, a.cell_uv_flags, a.cell_uv_cmp_flags} = n == 23 ? 42'h0 : 42'({sparse(), sparse()});
      {a.aux_ov_flags, a.aux_ov_cmp_flags, a.aux_uv_flags, a.aux_uv_cmp_flags} = n == 23 ? 24'h0 : 24'(sparse());
      for (int i = 0; i < 14; i++) begin
        m = rnd();
        a.cell_volt[i] = n == 0 ? (pol[i] ? bip : uni) + 16'(i % 2) : m[15:0];
      end
      acquire(a);
      rd_chk(cov_a, {18'h0, ov_exp});
      sum_chk();
    end
    end_test("acquisition");
    wr(sum_a, 32'hffffffff);
    wr(cov_a, 32'hffffffff);
    bus(1'b1, `ADDR_UNIPOLAR_OV_THRESHOLD, 32'h1234, 3'h1);
    sum_chk();
    rd_chk(cov_a, {18'h0, ov_exp});
    rd_chk(`ADDR_UNIPOLAR_OV_THRESHOLD, {16'h0, uni});
    ce <= 1'b0;
    a = '1;
    acquire(a);
    ce <= 1'b1;
    sum_chk();
    end_test("read only and frozen");
    for (int k = 0; k < 5; k++) begin
      calibrate(k, k >= 2 ? 16'h0101 : 16'h9001, 1'b0);
      sum_chk();
      calibrate(k, k >= 2 ? 16'hff01 : 16'h9000, 1'b1);
      sum_chk();
    end
    for (int n = 0; n < 30; n++) begin
      m = rnd();
      calibrate(int'(m[7:0] % 8'd5), m[4] ? m[31:16] : m[5] ? {{7{m[24]}}, m[24:16]} : 16'h7000 + {3'h0, m[28:16]},
        m[3]);
      sum_chk();
    end
    end_test("calibration");
    resetn <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b1;
    sum_exp = 16'h0;
    @(posedge ref_clk);
    sum_chk();
    end_test("second reset");
    final_report();
  end
endmodule
